//--- rtl/occ_channel.sv
`timescale 1ns/1ps
`include "occ_params.svh"
module occ_channel
    import occ_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] second_timer,
    input  wire logic [31:0] third_timer,
    input  wire logic        device_idle,
    input  wire logic        fault_pin_n,
    output logic             compare_output_pin,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers and helpers
    logic [31:0] ctrl;
    logic [31:0] primary_compare_value;
    logic [31:0] secondary_compare_value;
    logic        pwm_fault_flag;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  flt_sync;
    logic        fault_act;
    occ_seq_e    seq;
    logic [2:0]  mode_q;
    logic        last_on;

    function automatic logic cmp_eq(input logic [31:0] cnt, input logic [31:0] val, input logic wide);
        cmp_eq = wide ? (cnt == val) : (cnt[15:0] == val[15:0]);
    endfunction

    occ_mode_e   mode;
    logic        enabled;
    logic        running;
    logic        wide;
    logic [31:0] tcount;
    logic        pri_hit;
    logic        sec_hit;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    assign mode    = occ_mode_e'(ctrl[`OCC_MODE_LSB +: 3]);
    assign enabled = ctrl[`OCC_ON_BIT];
    assign running = enabled && !(ctrl[`OCC_IDLE_BIT] && device_idle);
    assign wide    = ctrl[`OCC_WIDE_BIT];
    assign tcount  = ctrl[`OCC_TSEL_BIT] ? third_timer : second_timer;
    assign pri_hit = running && cmp_eq(tcount, primary_compare_value, wide);
    assign sec_hit = running && cmp_eq(tcount, secondary_compare_value, wide);
    assign wr_en   = psel && penable && pwrite && pready;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `OCC_CTRL_OFS) || (paddr == `OCC_PRI_OFS) || (paddr == `OCC_SEC_OFS)
                  || (paddr == `OCC_IRQ_STAT_OFS) || (paddr == `OCC_IRQ_MASK_OFS);

    ////////////////////////////////////////////////////////////////////////
    // fault pin synchroniser, change accepted once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            flt_sync  <= 3'b111;
            fault_act <= 1'b0;
        end else begin
            flt_sync <= {flt_sync[1:0], fault_pin_n};
            if (flt_sync[1] == flt_sync[2]) begin
                fault_act <= !flt_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl                    <= `OCC_CTRL_RST;
            primary_compare_value   <= `OCC_CMP_RST;
            secondary_compare_value <= `OCC_CMP_RST;
            irq_mask                <= 3'b000;
        end else if (wr_en) begin
            unique case (paddr)
                `OCC_CTRL_OFS:     ctrl <= pwdata & `OCC_CTRL_WMASK & ~(32'h0000_0001 << `OCC_FLT_BIT);
                `OCC_PRI_OFS:      primary_compare_value   <= pwdata;
                `OCC_SEC_OFS:      secondary_compare_value <= pwdata;
                `OCC_IRQ_MASK_OFS: irq_mask <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                unique case (paddr)
                    `OCC_CTRL_OFS:     prdata <= ctrl | ({31'h0000_0000, pwm_fault_flag && mode == OCC_PWMFLT}
                                                << `OCC_FLT_BIT);
                    `OCC_PRI_OFS:      prdata <= primary_compare_value;
                    `OCC_SEC_OFS:      prdata <= secondary_compare_value;
                    `OCC_IRQ_STAT_OFS: prdata <= {29'h0000_0000, irq_stat};
                    `OCC_IRQ_MASK_OFS: prdata <= {29'h0000_0000, irq_mask};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flag, hardware set and hardware cleared on leaving fault pwm
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pwm_fault_flag <= 1'b0;
        end else if (running && mode == OCC_PWMFLT && fault_act) begin
            pwm_fault_flag <= 1'b1;
        end else if (!enabled || mode != OCC_PWMFLT) begin
            pwm_fault_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode change tracking, re-initialise the output on any change
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_q  <= 3'b000;
            last_on <= 1'b0;
        end else begin
            mode_q  <= mode;
            last_on <= enabled;
        end
    end

    logic reinit;
    assign reinit = (mode_q != mode) || (last_on != enabled);

    ////////////////////////////////////////////////////////////////////////
    // pulse sequencer for single and continuous pulse modes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            seq <= OCC_ARM;
        end else if (reinit || !enabled) begin
            seq <= OCC_ARM;
        end else if (running) begin
            unique case (seq)
                OCC_ARM:  seq <= OCC_RISE;
                OCC_RISE: if (pri_hit) seq <= OCC_FALL;
                OCC_FALL: if (sec_hit) seq <= (mode == OCC_CONT) ? OCC_RISE : OCC_DONE;
                OCC_DONE: seq <= OCC_DONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            compare_output_pin <= 1'b0;
        end else if (!enabled) begin
            compare_output_pin <= 1'b0;
        end else if (reinit) begin
            compare_output_pin <= (mode == OCC_SETLO);
        end else if (running) begin
            unique case (mode)
                OCC_OFF:    compare_output_pin <= 1'b0;
                OCC_SETHI:  if (pri_hit) compare_output_pin <= 1'b1;
                OCC_SETLO:  if (pri_hit) compare_output_pin <= 1'b0;
                OCC_TOGGLE: if (pri_hit) compare_output_pin <= !compare_output_pin;
                OCC_SINGLE, OCC_CONT: begin
                    if (seq == OCC_RISE && pri_hit) begin
                        compare_output_pin <= 1'b1;
                    end else if (seq == OCC_FALL && sec_hit) begin
                        compare_output_pin <= 1'b0;
                    end
                end
                OCC_PWM, OCC_PWMFLT: begin
                    if (mode == OCC_PWMFLT && (fault_act || pwm_fault_flag)) begin
                        compare_output_pin <= 1'b0;
                    end else if (pri_hit) begin
                        compare_output_pin <= 1'b1;
                    end else if (sec_hit) begin
                        compare_output_pin <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts, sticky, write one to clear, set wins over clear
    logic [2:0] ev;
    assign ev = {running && mode == OCC_PWMFLT && fault_act, sec_hit && mode != OCC_OFF, pri_hit && mode != OCC_OFF};

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_stat <= 3'b000;
        end else begin
            irq_stat <= (irq_stat & ~((wr_en && paddr == `OCC_IRQ_STAT_OFS) ? pwdata[2:0] : 3'b000)) | ev;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_off_low;
        @(posedge core_clk) disable iff (!resetn) !enabled |=> !compare_output_pin;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin high while disabled");

    property p_idle_hold;
        @(posedge core_clk) disable iff (!resetn)
            (enabled && ctrl[`OCC_IDLE_BIT] && device_idle && !reinit) |=> $stable(compare_output_pin);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("pin moved in idle");

    property p_flt_ro;
        @(posedge core_clk) disable iff (!resetn)
            (!(running && mode == OCC_PWMFLT && fault_act)) |=> !$rose(pwm_fault_flag);
    endproperty
    a_flt_ro: assert property (p_flt_ro) else $error("fault flag rose without fault");

    property p_unimpl;
        @(posedge core_clk) disable iff (!resetn) (psel && !penable && !pwrite && paddr == `OCC_CTRL_OFS)
            |=> (prdata & ~(`OCC_CTRL_WMASK | (32'h0000_0001 << `OCC_FLT_BIT))) == 32'h0000_0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");

    property p_toggle;
        @(posedge core_clk) disable iff (!resetn)
            (mode == OCC_TOGGLE && pri_hit && !reinit) |=> (compare_output_pin != $past(compare_output_pin));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_sethi;
        @(posedge core_clk) disable iff (!resetn)
            (enabled && mode == OCC_SETHI && pri_hit && !reinit) |=> compare_output_pin;
    endproperty
    a_sethi: assert property (p_sethi) else $error("set high missed");

    property p_setlo;
        @(posedge core_clk) disable iff (!resetn)
            (enabled && mode == OCC_SETLO && pri_hit && !reinit) |=> !compare_output_pin;
    endproperty
    a_setlo: assert property (p_setlo) else $error("force low missed");

    property p_fault;
        @(posedge core_clk) disable iff (!resetn)
            (running && mode == OCC_PWMFLT && fault_act && !reinit) |=> (!compare_output_pin && pwm_fault_flag);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not honoured");

    property p_single;
        @(posedge core_clk) disable iff (!resetn) (seq == OCC_DONE && mode == OCC_SINGLE) |-> !compare_output_pin;
    endproperty
    a_single: assert property (p_single) else $error("extra single pulse");

    // fault flag hidden on control reads outside fault pwm
    property p_flt_zero;
        @(posedge core_clk) disable iff (!resetn)
            (psel && !penable && !pwrite && paddr == `OCC_CTRL_OFS && mode != OCC_PWMFLT)
            |=> !prdata[`OCC_FLT_BIT];
    endproperty
    a_flt_zero: assert property (p_flt_zero) else $error("fault flag visible outside fault pwm");

    // mode or enable change starts low unless force-low mode
    property p_init_lo;
        @(posedge core_clk) disable iff (!resetn)
            (enabled && reinit && mode != OCC_SETLO) |=> !compare_output_pin;
    endproperty
    a_init_lo: assert property (p_init_lo) else $error("pin not initialised low");

    // force-low mode starts high
    property p_init_hi;
        @(posedge core_clk) disable iff (!resetn)
            (enabled && reinit && mode == OCC_SETLO) |=> compare_output_pin;
    endproperty
    a_init_hi: assert property (p_init_hi) else $error("pin not initialised high");

    // plain pwm raises on primary match even with the fault input active
    property p_pwm_rise;
        @(posedge core_clk) disable iff (!resetn)
            (running && mode == OCC_PWM && pri_hit && !reinit) |=> compare_output_pin;
    endproperty
    a_pwm_rise: assert property (p_pwm_rise) else $error("pwm rise missed");

    // mode off keeps the pin low
    property p_off_mode;
        @(posedge core_clk) disable iff (!resetn)
            (running && mode == OCC_OFF && !reinit) |=> !compare_output_pin;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("pin active in mode off");

    // primary match is recorded as a sticky event
    property p_evt;
        @(posedge core_clk) disable iff (!resetn)
            (pri_hit && mode != OCC_OFF) |=> irq_stat[`OCC_IRQ_MATCH_BIT];
    endproperty
    a_evt: assert property (p_evt) else $error("match event not recorded");

    // interrupt follows unmasked status one cycle later
    property p_irq_lvl;
        @(posedge core_clk) disable iff (!resetn)
            (|(irq_stat & irq_mask)) |=> irq;
    endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("interrupt not raised");

    c_toggle: cover property (@(posedge core_clk) disable iff (!resetn) mode == OCC_TOGGLE && pri_hit);
    c_pwm:    cover property (@(posedge core_clk) disable iff (!resetn) mode == OCC_PWM && $fell(compare_output_pin));
    c_fault:  cover property (@(posedge core_clk) disable iff (!resetn) $rose(pwm_fault_flag));
    c_irq:    cover property (@(posedge core_clk) disable iff (!resetn) $rose(irq));
    c_single: cover property (@(posedge core_clk) disable iff (!resetn) seq == OCC_DONE && mode == OCC_SINGLE);

endmodule

//--- common/occ_params.svh
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
// register byte offsets
`define OCC_CTRL_OFS      12'h000
`define OCC_PRI_OFS       12'h004
`define OCC_SEC_OFS       12'h008
`define OCC_IRQ_STAT_OFS  12'h00C
`define OCC_IRQ_MASK_OFS  12'h010
// control field positions
`define OCC_ON_BIT        15
`define OCC_IDLE_BIT      13
`define OCC_WIDE_BIT      5
`define OCC_FLT_BIT       4
`define OCC_TSEL_BIT      3
`define OCC_MODE_LSB      0
// writable mask of control register
`define OCC_CTRL_WMASK    32'h0000_A02F
// reset values
`define OCC_CTRL_RST      32'h0000_0000
`define OCC_CMP_RST       32'h0000_0000
// interrupt status bits
`define OCC_IRQ_MATCH_BIT 0
`define OCC_IRQ_SEC_BIT   1
`define OCC_IRQ_FLT_BIT   2
`define OCC_IRQ_W         3
`endif

//--- common/occ_pkg.sv
package occ_pkg;
    typedef enum logic [2:0] {
        OCC_OFF    = 3'b000,
        OCC_SETHI  = 3'b001,
        OCC_SETLO  = 3'b010,
        OCC_TOGGLE = 3'b011,
        OCC_SINGLE = 3'b100,
        OCC_CONT   = 3'b101,
        OCC_PWM    = 3'b110,
        OCC_PWMFLT = 3'b111
    } occ_mode_e;
    // pulse sequencer, gray along arm -> wait-rise -> wait-fall -> done
    typedef enum logic [1:0] {
        OCC_ARM  = 2'b00,
        OCC_RISE = 2'b01,
        OCC_FALL = 2'b11,
        OCC_DONE = 2'b10
    } occ_seq_e;
endpackage

//--- dv/occ_timer_model.sv
`timescale 1ns/1ps
// time bases on the far side of the channel: one fast, one slow
module occ_timer_model #(
    parameter int          SEC_PERIOD = 64,
    parameter int          THR_PERIOD = 48,
    parameter logic [31:0] THR_BASE   = 32'h0001_0000
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    output logic      [31:0] second_timer,
    output logic      [31:0] third_timer
);
    logic [31:0] thr_cnt;
    logic        thr_tick;
    // fast base: one count per clock, wraps so matches recur
    always_ff @(posedge core_clk) begin
        if (!resetn || second_timer == 32'(SEC_PERIOD - 1)) begin
            second_timer <= 32'h0000_0000;
        end else begin
            second_timer <= second_timer + 32'h0000_0001;
        end
    end
    // slow base: one count every other clock
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            thr_cnt  <= 32'h0000_0000;
            thr_tick <= 1'b0;
        end else begin
            thr_tick <= !thr_tick;
            if (thr_tick) begin
                thr_cnt <= (thr_cnt == 32'(THR_PERIOD - 1)) ? 32'h0000_0000 : thr_cnt + 32'h0000_0001;
            end
        end
    end
    // upper half set so a narrow compare differs from a wide one
    assign third_timer = THR_BASE | thr_cnt;
endmodule

//--- dv/output_compare_pwm_tb_top.sv
`timescale 1ns/1ps
`include "occ_params.svh"
module output_compare_pwm_tb_top;
    import occ_pkg::*;
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        device_idle, fault_pin_n, compare_output_pin, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, second_timer, third_timer, r;
    int          fails, n_checks;
    ////////////////////////////////////////////////////////////////
    occ_channel dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .second_timer(second_timer), .third_timer(third_timer),
        .device_idle(device_idle), .fault_pin_n(fault_pin_n),
        .compare_output_pin(compare_output_pin), .irq(irq));
    occ_timer_model tmr_u (.core_clk(core_clk), .resetn(resetn),
        .second_timer(second_timer), .third_timer(third_timer));
    // clock
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    // one apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd_q, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_q = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
            fails++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        er;
        apb(1'b1, a, d, q, er);
        chk({31'h0, er}, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, q, er);
        chk(q, x);
    endtask
    // disable, then load a new control word
    task automatic cfg(input logic [31:0] v);
        wr(`OCC_CTRL_OFS, 32'h0000_0000);
        wr(`OCC_CTRL_OFS, v);
    endtask
    // wait, bounded, for a pin level
    task automatic see(input logic v, input int lim);
        int i;
        i = 0;
        while (compare_output_pin !== v && i < lim) begin
            @(posedge core_clk);
            i++;
        end
        chk({31'h0, compare_output_pin}, {31'h0, v});
    endtask
    // count rising pin edges over n cycles, expect lo..hi
    task automatic rises(input int n, input int lo, input int hi);
        int   k;
        logic p;
        k = 0;
        p = compare_output_pin;
        repeat (n) begin
            @(posedge core_clk);
            if (compare_output_pin === 1'b1 && p !== 1'b1) k++;
            p = compare_output_pin;
        end
        chk({31'h0, k >= lo && k <= hi}, 32'h0000_0001);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (8000) @(posedge core_clk);
        fails++;
        $display("watchdog expired");
        test_done;
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, device_idle} = 4'h0;
        {paddr, pwdata} = 44'h0;
        fault_pin_n = 1'b1;
        resetn = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(`OCC_CTRL_OFS, 32'h0000_0000);
        rd(`OCC_PRI_OFS, 32'h0000_0000);
        wr(`OCC_CTRL_OFS, 32'hFFFF_FFFF);
        rd(`OCC_CTRL_OFS, 32'h0000_A02F);
        apb(1'b0, 12'h014, 32'h0000_0000, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        $display("registers test done");
        wr(`OCC_PRI_OFS, 32'h0000_001E);
        wr(`OCC_SEC_OFS, 32'h0000_0032);
        cfg(32'h0000_8001);
        wr(`OCC_IRQ_STAT_OFS, 32'h0000_0007);
        see(1'b0, 2);
        see(1'b1, 70);
        apb(1'b0, `OCC_IRQ_STAT_OFS, 32'h0000_0000, r, e);
        chk({31'h0, r[0]}, 32'h0000_0001);
        wr(`OCC_IRQ_MASK_OFS, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`OCC_CTRL_OFS, 32'h0000_0000);
        wr(`OCC_IRQ_STAT_OFS, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`OCC_IRQ_MASK_OFS, 32'h0000_0000);
        $display("set-high and interrupt test done");
        cfg(32'h0000_8002);
        see(1'b1, 3);
        see(1'b0, 70);
        cfg(32'h0000_8003);
        see(1'b1, 70);
        see(1'b0, 70);
        cfg(32'h0000_8004);
        see(1'b0, 2);
        rises(300, 1, 1);
        cfg(32'h0000_8005);
        see(1'b0, 2);
        rises(300, 3, 5);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("compare mode test done");
        fault_pin_n <= 1'b0;
        cfg(32'h0000_8006);
        rises(300, 3, 5);
        cfg(32'h0000_8007);
        repeat (8) @(posedge core_clk);
        see(1'b0, 2);
        rises(150, 0, 0);
        wr(`OCC_CTRL_OFS, 32'h0000_8007);
        rd(`OCC_CTRL_OFS, 32'h0000_8017);
        apb(1'b0, `OCC_IRQ_STAT_OFS, 32'h0000_0000, r, e);
        chk({31'h0, r[2]}, 32'h0000_0001);
        fault_pin_n <= 1'b1;
        wr(`OCC_CTRL_OFS, 32'h0000_8006);
        rd(`OCC_CTRL_OFS, 32'h0000_8006);
        $display("pwm fault test done");
        wr(`OCC_PRI_OFS, 32'h0001_0005);
        cfg(32'h0000_8029);
        see(1'b1, 200);
        cfg(32'h0000_8021);
        rises(150, 0, 0);
        cfg(32'h0000_8001);
        see(1'b1, 70);
        $display("time base test done");
        device_idle <= 1'b1;
        cfg(32'h0000_A003);
        rises(150, 0, 0);
        cfg(32'h0000_8003);
        rises(150, 1, 3);
        device_idle <= 1'b0;
        cfg(32'h0000_0001);
        rises(150, 0, 0);
        cfg(32'h0000_8000);
        rises(150, 0, 0);
        $display("enable and idle test done");
        test_done;
    end
endmodule
